// ### hw/dlev_pkg.sv
// Package for the data link one event status block
//------------------------------------------------------------
// Operation
//------------------------------------------------------------
package dlev_pkg;
   localparam logic [7:0] DLEV_STATUS_ADDR = 8'h09;
   localparam logic [7:0] DLEV_ENABLE_ADDR = 8'h11;
   localparam logic [7:0] DLEV_STATUS_RST  = 8'h00;
   localparam logic [7:0] DLEV_ENABLE_RST  = 8'h00;
   localparam int BIT_CODEWORD  = 7;
   localparam int BIT_RXFULL    = 6;
   localparam int BIT_RXNEAR    = 5;
   localparam int BIT_RXMSG     = 4;
   localparam int BIT_UNDERRUN  = 3;
   localparam int BIT_OVERFLOW  = 2;
   localparam int BIT_TXNEAR    = 1;
   localparam int BIT_TXMSG     = 0;

   // Raw event conditions from the data link controller
   typedef struct packed {
      logic codewordSent;
      logic rxOverrun;
      logic rxFillReached;
      logic rxNearFull;
      logic rxMessage;
      logic txUnderrun;
      logic txFullWrite;
      logic txNearEmpty;
      logic txMessageDone;
   } dlev_src_t;
endpackage : dlev_pkg

// ### hw/dlev_status.sv
// Data link one event status register with edge latching and read clear
`timescale 1ns/1ps
module dlev_status
   import dlev_pkg::*;
(
   input  wire logic      clk_sys,
   input  wire logic      rst_n,
   input  wire logic [7:0] addr,
   input  wire logic      rdStb,
   input  wire logic      wrStb,
   input  wire logic [7:0] wrData,
   input  wire logic      packMode,
   input  wire dlev_src_t src,
   output logic     [7:0] rdData,
   output logic           irq,
   output logic           txAbort,
   output logic           txFifoWrAccept
);
   //------------------------------------------------------------
   // Source edge detection
   //------------------------------------------------------------
   logic [7:0] srcReg;
   logic [7:0] statusReg;
   logic [7:0] statusNext;
   logic [7:0] enableReg;
   logic [7:0] srcLevel;
   logic [7:0] srcRise;
   wire        statusRead = rdStb && (addr == DLEV_STATUS_ADDR);
   wire        enableWrite = wrStb && (addr == DLEV_ENABLE_ADDR);

   // Fill limit source in packing modes
   wire rxFullSrc = packMode ? src.rxFillReached : src.rxOverrun;
   assign srcLevel = {src.codewordSent, rxFullSrc, src.rxNearFull, src.rxMessage,
                      src.txUnderrun, src.txFullWrite, src.txNearEmpty,
                      src.txMessageDone};
   assign srcRise = srcLevel & ~srcReg;
   assign statusNext = (statusRead ? 8'h00 : statusReg) | srcRise;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         srcReg <= 8'h00;
         statusReg <= DLEV_STATUS_RST;
         enableReg <= DLEV_ENABLE_RST;
      end else begin
         srcReg <= srcLevel;
         statusReg <= statusNext;
         if (enableWrite) begin
            enableReg <= wrData;
         end
      end
   end

   //------------------------------------------------------------
   // Outputs
   //------------------------------------------------------------
   wire [7:0] rdNext = (addr == DLEV_STATUS_ADDR) ? statusReg :
                       (addr == DLEV_ENABLE_ADDR) ? enableReg : 8'h00;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdData <= 8'h00;
         irq <= 1'b0;
         txAbort <= 1'b0;
         txFifoWrAccept <= 1'b0;
      end else begin
         rdData <= rdStb ? rdNext : 8'h00;
         irq <= |(statusNext & enableReg);
         txAbort <= src.txUnderrun;
         txFifoWrAccept <= ~src.txFullWrite;
      end
   end

   //------------------------------------------------------------
   // Assertions
   //------------------------------------------------------------
   edge_latch_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      srcRise[BIT_UNDERRUN] |=> statusReg[BIT_UNDERRUN])
      else $error("underrun edge not latched");
   read_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      statusRead && srcRise == 8'h00 |=> statusReg == 8'h00)
      else $error("status read did not clear");
   hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !statusRead && statusReg[BIT_TXNEAR] |=> statusReg[BIT_TXNEAR])
      else $error("status bit dropped without read");
   irq_out_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      irq == |($past(statusNext) & $past(enableReg)))
      else $error("interrupt does not match status and enable");
   codeword_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(src.codewordSent) |=> statusReg[BIT_CODEWORD])
      else $error("codeword bit not set");
   overrun_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !packMode && $rose(src.rxOverrun) && !srcReg[BIT_RXFULL] |=> statusReg[BIT_RXFULL])
      else $error("overrun bit not set");
   fill_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      packMode && $rose(src.rxFillReached) && !srcReg[BIT_RXFULL] |=> statusReg[BIT_RXFULL])
      else $error("fill limit bit not set");
   abort_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      src.txUnderrun |=> txAbort)
      else $error("abort not forced");
   discard_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      src.txFullWrite |=> !txFifoWrAccept)
      else $error("overflow write accepted");
   overflow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      srcRise[BIT_OVERFLOW] |=> statusReg[BIT_OVERFLOW])
      else $error("overflow bit not set");
   race_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      statusRead && srcRise[BIT_RXNEAR] |=> statusReg[BIT_RXNEAR])
      else $error("edge lost on clearing read");
endmodule : dlev_status

// ### tb/tb_top.sv
// Bench for the data link one event status block
`timescale 1ns/1ps
module tb_top
   import dlev_pkg::*;
;
   typedef struct packed {logic [8:0] s; logic p; logic [7:0] e;} dlev_row_t;
   logic       clk_sys = 0, rst_n = 0, rdStb = 0, wrStb = 0, packMode = 0, irq, txAbort, txAcc;
   logic [7:0] addr = 8'h00, wrData = 8'h00, rdData, d;
   dlev_src_t  src = '0;
   int         nFail = 0, checkCount = 0, cyc = 0;
   dlev_row_t  rows[11] = '{'{9'h100,0,8'h80}, '{9'h080,0,8'h40}, '{9'h040,1,8'h40},
      '{9'h040,0,8'h00}, '{9'h080,1,8'h00}, '{9'h020,0,8'h20}, '{9'h010,0,8'h10},
      '{9'h008,0,8'h08}, '{9'h004,0,8'h04}, '{9'h002,0,8'h02}, '{9'h001,0,8'h01}};
   dlev_status dut (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .rdStb(rdStb),
      .wrStb(wrStb), .wrData(wrData), .packMode(packMode), .src(src), .rdData(rdData),
      .irq(irq), .txAbort(txAbort), .txFifoWrAccept(txAcc));
   initial forever #20 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 1000) begin
         nFail++;
         complete_run();
      end
   end
   task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
      checkCount++;
      if (g !== e) begin
         nFail++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask : chk8
   task automatic chk1(string n, logic e, logic g);
      chk8(n, {7'h00, e}, {7'h00, g});
   endtask : chk1
   task automatic acc(logic [7:0] a, logic w, logic [7:0] v);
      @(posedge clk_sys) #1;
      addr = a; wrData = v; rdStb = !w; wrStb = w;
      @(posedge clk_sys) #1;
      rdStb = 0; wrStb = 0; d = rdData;
   endtask : acc
   task automatic pulse(logic [8:0] s);
      @(posedge clk_sys) #1 src = s;
      @(posedge clk_sys) #1 src = '0;
   endtask : pulse
   task complete_run;
      $display("checks %0d mismatches %0d", checkCount, nFail);
      if (nFail == 0 && checkCount > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : complete_run
   initial begin
      repeat (20) @(posedge clk_sys);
      chk1("irq in reset", 1'b0, irq);
      #1 rst_n = 1;
      acc(8'h09, 0, 8'h00); chk8("status after reset", 8'h00, d);
      acc(8'h11, 1, 8'hFF);
      foreach (rows[i]) begin
         packMode = rows[i].p;
         pulse(rows[i].s);
         @(posedge clk_sys) #1 chk1("irq", |rows[i].e, irq);
         acc(8'h09, 0, 8'h00); chk8("status", rows[i].e, d);
         acc(8'h09, 0, 8'h00); chk8("cleared", 8'h00, d);
         @(posedge clk_sys) #1 chk1("irq cleared", 1'b0, irq);
      end
      $display("test table done");
      packMode = 0; src.txUnderrun = 1;
      repeat (3) @(posedge clk_sys);
      #1 chk1("abort", 1'b1, txAbort);
      acc(8'h09, 0, 8'h00); chk8("level once", 8'h08, d);
      acc(8'h09, 0, 8'h00); chk8("level again", 8'h00, d);
      src = '0; src.txFullWrite = 1;
      @(posedge clk_sys) #1 chk1("write accept", 1'b0, txAcc);
      src = '0;
      @(posedge clk_sys) #1;
      addr = 8'h09; rdStb = 1; src = 9'h020;
      @(posedge clk_sys) #1;
      rdStb = 0; src = '0; chk8("read at edge", 8'h04, rdData);
      acc(8'h09, 0, 8'h00); chk8("kept edge", 8'h20, d);
      $display("test edges done");
      acc(8'h11, 1, 8'h00);
      pulse(9'h100);
      @(posedge clk_sys) #1 chk1("masked irq", 1'b0, irq);
      acc(8'h09, 1, 8'hFF);
      acc(8'h3C, 0, 8'h00); chk8("unmapped", 8'h00, d);
      acc(8'h09, 0, 8'h00); chk8("status not writable", 8'h80, d);
      $display("test access done");
      complete_run();
   end
endmodule : tb_top
